// ===== verif/pwm_bus_master.sv
/*
 * APB host model standing in for the processor side of the PWM slice.
 * Assumes a single clock and a slave that raises pready after access.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_bus_master (
  input  wire logic        i_sys_clk,
  input  wire logic        i_pready,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [11:0] o_paddr,
  output logic      [31:0] o_pwdata
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0000_0000;
  end

  // One transfer: setup, access held until pready
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge i_sys_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= wr;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_sys_clk);
    o_penable <= 1'b1;
    do @(posedge i_sys_clk); while (i_pready !== 1'b1);
    q   = i_prdata;
    err = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_paddr   <= ~a;
    o_pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== verif/pwm_irq_status_and_load_test.sv
/*
 * Self-checking bench for the PWM interrupt-status and load slice.
 * Assumes the APB host model and the design package.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_irq_status_and_load_test
  import pwm_irq_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        sync = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel, pen, pwr, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [31:0] q;
  logic        e;

  always #5 clk = ~clk;

  pwm_irq_top DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_clk_en(clk_en),
    .i_sync(sync), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .o_irq(irq));

  pwm_bus_master u_host (.i_sys_clk(clk), .i_pready(pready),
    .i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
    .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata));

  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask

  task automatic t_reset();
    for (int n = 0; n < NUM_INST; n++) begin
      rd(RAW_OFS[n], 32'h0000_0000);
      rd(ISC_OFS[n], 32'h0000_0000);
      rd(LOAD_OFS[n], 32'h0000_0000);
    end
    chk({31'h0, irq}, 32'h0000_0000);
    $display("done: reset values");
  endtask

  task automatic t_regs();
    wr(LOAD_OFS[0], 32'hFFFF_FFFF);
    rd(LOAD_OFS[0], 32'h000F_FFFF);
    wr(LOAD_OFS[2], 32'hABC3_1234);
    rd(LOAD_OFS[2], 32'h0003_1234);
    wr(RAW_OFS[0], 32'hFFFF_FFFF);
    rd(RAW_OFS[0], 32'h0000_0000);
    u_host.xfer(1'b0, 12'h0F0, 32'h0000_0000, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(q, 32'h0000_0000);
    $display("done: register access");
  endtask

  task automatic t_zero();
    wr(LOAD_OFS[0], 32'h0000_0000);
    wr(CTRL_OFS[0], 32'h0000_0001);
    rd(RAW_OFS[0], 32'h0000_00AB);
    rd(ISC_OFS[0], 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(INTEN_OFS[0], 32'h0000_0003);
    rd(ISC_OFS[0], 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(CTRL_OFS[0], 32'h0000_0000);
    wr(ISC_OFS[0], 32'h0000_0000);
    rd(ISC_OFS[0], 32'h0000_0003);
    wr(ISC_OFS[0], 32'h0000_0001);
    rd(ISC_OFS[0], 32'h0000_0002);
    wr(ISC_OFS[0], 32'h0000_0002);
    clk_en <= 1'b0;
    repeat (5) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    clk_en <= 1'b1;
    rd(ISC_OFS[0], 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("done: zero and load events");
  endtask

  // Counting modes, one per instance
  task automatic t_modes();
    logic [1:0]  md [3] = '{MODE_UP, MODE_UPDOWN, MODE_DOWN};
    logic [31:0] ex [3] = '{32'h57, 32'hFF, 32'hAB};
    for (int n = 0; n < NUM_INST; n++) begin
      wr(LOAD_OFS[n], 32'h0000_0004);
      wr(CMPA_OFS[n], 32'h0000_0002);
      wr(CMPB_OFS[n], 32'h0000_0003);
      wr(CMPC_OFS[n], 32'h0000_0001);
      wr(INTEN_OFS[n], 32'h0000_00FF);
      wr(CTRL_OFS[n], {29'h0, md[n], 1'b1});
      repeat (40) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(CTRL_OFS[n], 32'h0000_0000);
      rd(ISC_OFS[n], ex[n]);
      wr(ISC_OFS[n], 32'h0000_00FF);
      rd(ISC_OFS[n], 32'h0000_0000);
    end
    $display("done: counting modes");
  endtask

  task automatic t_sync();
    wr(LOAD_OFS[0], 32'h0000_0002);
    wr(CMPA_OFS[0], 32'h0000_0003);
    wr(CTRL_OFS[0], 32'h0000_000B);
    repeat (40) @(posedge clk);
    wr(CTRL_OFS[0], 32'h0000_0000);
    rd(ISC_OFS[0], 32'h0000_0057);
    @(posedge clk) sync <= 1'b1;
    wr(CTRL_OFS[0], 32'h0000_000B);
    repeat (40) @(posedge clk);
    wr(ISC_OFS[0], 32'h0000_00FF);
    repeat (40) @(posedge clk);
    wr(CTRL_OFS[0], 32'h0000_0000);
    rd(ISC_OFS[0], 32'h0000_0043);
    $display("done: synchronized load");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_zero();
    t_modes();
    t_sync();
    finish_test();
  end
endmodule
`default_nettype wire

// ===== verilog/pwm_counter.sv
/*
 * Prescaled 16-bit counter with down, up and up/down modes and the
 * eight match events, each a one-cycle registered pulse per count step.
 * Assumes load and compare values are stable register outputs.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_counter
  import pwm_irq_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_clk_en,
  input  wire logic             i_run,
  input  wire logic [1:0]       i_mode,
  input  wire logic [3:0]       i_scale,
  input  wire logic [CNT_W-1:0] i_load,
  input  wire logic [CNT_W-1:0] i_cmpa,
  input  wire logic [CNT_W-1:0] i_cmpb,
  input  wire logic [CNT_W-1:0] i_cmpc,
  output logic      [CNT_W-1:0] o_count,
  output logic      [7:0]       o_evt
);
  logic [3:0] psc_r;
  logic       dir_down_r;
  logic       tick;
  logic       down_eff;
  logic [7:0] evt_nxt;

  assign tick = i_run && (psc_r == i_scale);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      psc_r <= 4'h0;
    end else if (i_clk_en) begin
      psc_r <= (!i_run || tick) ? 4'h0 : psc_r + 4'h1;
    end
  end

  always_comb begin
    case (i_mode)
      MODE_DOWN: down_eff = 1'b1;
      MODE_UP:   down_eff = 1'b0;
      default:   down_eff = dir_down_r && (o_count != i_load);
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count    <= VAL_RESET;
      dir_down_r <= 1'b0;
    end else if (i_clk_en && tick) begin
      case (i_mode)
        MODE_DOWN: begin
          o_count <= (o_count == '0) ? i_load : o_count - CNT_W'(1);
        end
        MODE_UP: begin
          o_count <= (o_count >= i_load) ? '0 : o_count + CNT_W'(1);
        end
        default: begin
          if (!dir_down_r && o_count >= i_load) begin
            dir_down_r <= 1'b1;
            o_count    <= (o_count == '0) ? '0 : o_count - CNT_W'(1);
          end else if (dir_down_r && o_count == '0) begin
            dir_down_r <= 1'b0;
            o_count    <= (i_load == '0) ? '0 : o_count + CNT_W'(1);
          end else begin
            o_count <= dir_down_r ? o_count - CNT_W'(1) : o_count + CNT_W'(1);
          end
        end
      endcase
    end
  end

  always_comb begin
    evt_nxt = 8'h00;
    evt_nxt[BIT_ZERO]   = (o_count == '0);
    evt_nxt[BIT_LOAD]   = (o_count == i_load);
    evt_nxt[BIT_A_UP]   = (o_count == i_cmpa) && !down_eff;
    evt_nxt[BIT_A_DOWN] = (o_count == i_cmpa) && down_eff;
    evt_nxt[BIT_B_UP]   = (o_count == i_cmpb) && !down_eff;
    evt_nxt[BIT_B_DOWN] = (o_count == i_cmpb) && down_eff;
    evt_nxt[BIT_C_UP]   = (o_count == i_cmpc) && !down_eff;
    evt_nxt[BIT_C_DOWN] = (o_count == i_cmpc) && down_eff;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_evt <= EVT_RESET;
    end else if (i_clk_en) begin
      o_evt <= tick ? evt_nxt : EVT_RESET;
    end
  end

  property p_down_reload;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && tick && i_mode == MODE_DOWN && o_count == '0) |=> (o_count == $past(i_load));
  endproperty
  a_down_reload: assert property (p_down_reload) else $error("down count did not reload");

  property p_up_wrap;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && tick && i_mode == MODE_UP && o_count >= i_load) |=> (o_count == '0);
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up count did not wrap");
endmodule
`default_nettype wire

// ===== verilog/pwm_irq_pkg.sv
/*
 * Register map, field positions and reset values for the three PWM
 * interrupt-status and load-value slices.
 * Assumes a 12-bit APB byte address and 32-bit data.
 */
package pwm_irq_pkg;
  localparam int          NUM_INST              = 3;
  localparam int          ADDR_W                = 12;
  localparam logic [31:0] REG_RESET             = 32'h0000_0000;
  localparam logic [7:0]  EVT_RESET             = 8'h00;
  localparam logic [3:0]  CTRL_RESET            = 4'h0;
  localparam logic [19:0] LOAD_RESET            = 20'h0_0000;
  localparam logic [15:0] VAL_RESET             = 16'h0000;
  // Byte addresses per instance
  localparam logic [11:0] RAW_OFS   [NUM_INST]  = '{12'h050, 12'h090, 12'h0D0};
  localparam logic [11:0] ISC_OFS   [NUM_INST]  = '{12'h054, 12'h094, 12'h0D4};
  localparam logic [11:0] LOAD_OFS  [NUM_INST]  = '{12'h058, 12'h098, 12'h008};
  localparam logic [11:0] COUNT_OFS [NUM_INST]  = '{12'h05C, 12'h09C, 12'h0DC};
  localparam logic [11:0] CMPA_OFS  [NUM_INST]  = '{12'h060, 12'h0A0, 12'h0E0};
  localparam logic [11:0] CMPB_OFS  [NUM_INST]  = '{12'h064, 12'h0A4, 12'h0E4};
  localparam logic [11:0] CMPC_OFS  [NUM_INST]  = '{12'h068, 12'h0A8, 12'h0E8};
  localparam logic [11:0] CTRL_OFS  [NUM_INST]  = '{12'h040, 12'h080, 12'h0C0};
  localparam logic [11:0] INTEN_OFS [NUM_INST]  = '{12'h044, 12'h084, 12'h0C4};
  // Event bit positions
  localparam int BIT_ZERO   = 0;
  localparam int BIT_LOAD   = 1;
  localparam int BIT_A_UP   = 2;
  localparam int BIT_A_DOWN = 3;
  localparam int BIT_B_UP   = 4;
  localparam int BIT_B_DOWN = 5;
  localparam int BIT_C_UP   = 6;
  localparam int BIT_C_DOWN = 7;
  // Load register fields
  localparam int LOAD_LSB  = 0;
  localparam int LOAD_MSB  = 15;
  localparam int SCALE_LSB = 16;
  localparam int SCALE_MSB = 19;
  // Control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 2;
  localparam int CTRL_SYNC = 3;
  // Counting modes
  localparam logic [1:0] MODE_DOWN   = 2'h0;
  localparam logic [1:0] MODE_UP     = 2'h1;
  localparam logic [1:0] MODE_UPDOWN = 2'h2;
  typedef enum logic [3:0] {
    K_NONE, K_RAW, K_ISC, K_LOAD, K_COUNT, K_CMPA, K_CMPB, K_CMPC, K_CTRL, K_INTEN
  } reg_kind_t;
endpackage

// ===== verilog/pwm_irq_top.sv
/*
 * APB register slice for three PWM instances: raw event status, write-one
 * clear interrupt status, interrupt enable, load/scale, compares, control.
 * Assumes an APB master on i_sys_clk; one wait state on every access.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - C match sets bit 7 down, 6 up
// - B match sets bit 5 down, 4 up
// - A match sets bit 3 down, 2 up
// - Load match sets raw bit 1
// - Zero count sets raw bit 0
// - Raw status ignores mask; upper bits zero
// - Writing one clears a status bit
// - Status set only for enabled events
// - Status layout mirrors raw layout
// - Down mode reloads load value at zero
// - Up mode wraps or turns at load
// - Immediate mode: new load at zero
// - Sync mode: new load at zero plus sync
// - Scale field bits 19:16, upper reserved
// - Enable bit gates event into status
// - Pure modes give five event kinds
module pwm_irq_top
  import pwm_irq_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_clk_en,
  input  wire logic              i_sync,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic      [31:0]       o_prdata,
  output logic                   o_pslverr,
  output logic                   o_irq
);
  logic [7:0]  raw_r   [NUM_INST];
  logic [7:0]  flag_r  [NUM_INST];
  logic [7:0]  inten_r [NUM_INST];
  logic [3:0]  ctrl_r  [NUM_INST];
  logic [19:0] load_r  [NUM_INST];
  logic [15:0] cmpa_r  [NUM_INST];
  logic [15:0] cmpb_r  [NUM_INST];
  logic [15:0] cmpc_r  [NUM_INST];
  logic [19:0] act     [NUM_INST];
  logic [15:0] count   [NUM_INST];
  logic [7:0]  evt     [NUM_INST];
  logic [NUM_INST-1:0] any_flag;

  reg_kind_t   kind;
  logic [1:0]  inst;
  logic        access;
  logic        done;
  logic        wr_done;
  logic [31:0] rd_val;

  function automatic reg_kind_t kind_of(input logic [ADDR_W-1:0] a);
    reg_kind_t k;
    k = K_NONE;
    for (int n = 0; n < NUM_INST; n++) begin
      if (a == RAW_OFS[n])   k = K_RAW;
      if (a == ISC_OFS[n])   k = K_ISC;
      if (a == LOAD_OFS[n])  k = K_LOAD;
      if (a == COUNT_OFS[n]) k = K_COUNT;
      if (a == CMPA_OFS[n])  k = K_CMPA;
      if (a == CMPB_OFS[n])  k = K_CMPB;
      if (a == CMPC_OFS[n])  k = K_CMPC;
      if (a == CTRL_OFS[n])  k = K_CTRL;
      if (a == INTEN_OFS[n]) k = K_INTEN;
    end
    return k;
  endfunction

  function automatic logic [1:0] inst_of(input logic [ADDR_W-1:0] a);
    logic [1:0] r;
    r = 2'h0;
    for (int n = 0; n < NUM_INST; n++) begin
      if (a == RAW_OFS[n] || a == ISC_OFS[n] || a == LOAD_OFS[n] ||
          a == COUNT_OFS[n] || a == CMPA_OFS[n] || a == CMPB_OFS[n] ||
          a == CMPC_OFS[n] || a == CTRL_OFS[n] || a == INTEN_OFS[n]) begin
        r = n[1:0];
      end
    end
    return r;
  endfunction

  assign kind    = kind_of(i_paddr);
  assign inst    = inst_of(i_paddr);
  assign access  = i_psel && i_penable;
  assign done    = access && o_pready;
  assign wr_done = done && i_pwrite && (kind != K_NONE);

  // Read mux, reserved bits zero
  always_comb begin
    rd_val = REG_RESET;
    case (kind)
      K_RAW:   rd_val[7:0]  = raw_r[inst];
      K_ISC:   rd_val[7:0]  = flag_r[inst];
      K_LOAD:  rd_val[19:0] = load_r[inst];
      K_COUNT: rd_val[15:0] = count[inst];
      K_CMPA:  rd_val[15:0] = cmpa_r[inst];
      K_CMPB:  rd_val[15:0] = cmpb_r[inst];
      K_CMPC:  rd_val[15:0] = cmpc_r[inst];
      K_CTRL:  rd_val[3:0]  = ctrl_r[inst];
      K_INTEN: rd_val[7:0]  = inten_r[inst];
      default: rd_val       = REG_RESET;
    endcase
  end

  // APB slave, one wait state
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_prdata  <= REG_RESET;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      if (access && !o_pready) begin
        o_pready  <= 1'b1;
        o_prdata  <= i_pwrite ? REG_RESET : rd_val;
        o_pslverr <= (kind == K_NONE);
      end else begin
        o_pready  <= 1'b0;
        o_pslverr <= 1'b0;
      end
    end
  end

  generate
    for (genvar g = 0; g < NUM_INST; g++) begin : g_inst
      logic wr_here;
      assign wr_here = wr_done && (inst == 2'(g));

      // Software registers
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          ctrl_r[g]  <= CTRL_RESET;
          inten_r[g] <= EVT_RESET;
          load_r[g]  <= LOAD_RESET;
          cmpa_r[g]  <= VAL_RESET;
          cmpb_r[g]  <= VAL_RESET;
          cmpc_r[g]  <= VAL_RESET;
        end else if (i_clk_en && wr_here) begin
          case (kind)
            K_CTRL:  ctrl_r[g]  <= i_pwdata[3:0];
            K_INTEN: inten_r[g] <= i_pwdata[7:0];
            K_LOAD:  load_r[g]  <= i_pwdata[SCALE_MSB:LOAD_LSB];
            K_CMPA:  cmpa_r[g]  <= i_pwdata[15:0];
            K_CMPB:  cmpb_r[g]  <= i_pwdata[15:0];
            K_CMPC:  cmpc_r[g]  <= i_pwdata[15:0];
            default: ctrl_r[g]  <= ctrl_r[g];
          endcase
        end
      end

      // Raw status follows events regardless of mask
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          raw_r[g] <= EVT_RESET;
        end else if (i_clk_en) begin
          raw_r[g] <= evt[g];
        end
      end

      // Sticky status, set wins over clear
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          flag_r[g] <= EVT_RESET;
        end else if (i_clk_en) begin
          flag_r[g] <= (flag_r[g] & ~((wr_here && kind == K_ISC) ? i_pwdata[7:0] : 8'h00))
                       | (evt[g] & inten_r[g]);
        end
      end

      assign any_flag[g] = |flag_r[g];

      pwm_load_shadow u_shadow (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_clk_en    (i_clk_en),
        .i_pend      (load_r[g]),
        .i_sync_mode (ctrl_r[g][CTRL_SYNC]),
        .i_sync      (i_sync),
        .i_zero      (evt[g][BIT_ZERO]),
        .o_act       (act[g])
      );

      pwm_counter #(
        .CNT_W (16)
      ) u_counter (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_clk_en  (i_clk_en),
        .i_run     (ctrl_r[g][CTRL_EN]),
        .i_mode    (ctrl_r[g][CTRL_MODE_MSB:CTRL_MODE_LSB]),
        .i_scale   (act[g][SCALE_MSB:SCALE_LSB]),
        .i_load    (act[g][LOAD_MSB:LOAD_LSB]),
        .i_cmpa    (cmpa_r[g]),
        .i_cmpb    (cmpb_r[g]),
        .i_cmpc    (cmpc_r[g]),
        .o_count   (count[g]),
        .o_evt     (evt[g])
      );
    end
  endgenerate

  // Interrupt line
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_irq <= |any_flag;
    end
  end

  property p_zero_raw;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && evt[0][BIT_ZERO]) |=> raw_r[0][BIT_ZERO];
  endproperty
  a_zero_raw: assert property (p_zero_raw) else $error("zero event lost in raw");

  property p_load_raw;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && evt[0][BIT_LOAD]) |=> raw_r[0][BIT_LOAD];
  endproperty
  a_load_raw: assert property (p_load_raw) else $error("load event lost in raw");

  property p_cmpa_raw;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      i_clk_en |=> (raw_r[0][3:2] == $past(evt[0][3:2]));
  endproperty
  a_cmpa_raw: assert property (p_cmpa_raw) else $error("compare A raw wrong");

  property p_cmpb_raw;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && evt[1][BIT_B_DOWN]) |=> raw_r[1][BIT_B_DOWN];
  endproperty
  a_cmpb_raw: assert property (p_cmpb_raw) else $error("compare B raw wrong");

  property p_cmpc_raw;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && evt[2][BIT_C_UP]) |=> raw_r[2][BIT_C_UP];
  endproperty
  a_cmpc_raw: assert property (p_cmpc_raw) else $error("compare C raw wrong");

  property p_w1c;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && wr_done && inst == 2'h0 && kind == K_ISC && i_pwdata[0] && !evt[0][0])
        |=> !flag_r[0][0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_masked;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ##1 ((flag_r[0] & ~$past(flag_r[0]) & ~$past(inten_r[0])) == 8'h00);
  endproperty
  a_masked: assert property (p_masked) else $error("masked event set status");

  property p_irq;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && (|any_flag)) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_load_reserved;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_pready && !i_pwrite && kind == K_LOAD) |-> (o_prdata[31:20] == 12'h000);
  endproperty
  a_load_reserved: assert property (p_load_reserved) else $error("load reserved bits set");

  property p_raw_reserved;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_pready && !i_pwrite && kind == K_RAW) |-> (o_prdata[31:8] == 24'h00_0000);
  endproperty
  a_raw_reserved: assert property (p_raw_reserved) else $error("raw reserved bits set");

  property p_isc_reserved;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_pready && !i_pwrite && kind == K_ISC) |-> (o_prdata[31:8] == 24'h00_0000);
  endproperty
  a_isc_reserved: assert property (p_isc_reserved) else $error("status reserved bits set");

  property p_sticky;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && !(wr_done && kind == K_ISC && inst == 2'h0))
        |=> ((flag_r[0] & $past(flag_r[0])) == $past(flag_r[0]));
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost without clear");

  property p_enabled_set;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && evt[0][BIT_LOAD] && inten_r[0][BIT_LOAD]) |=> flag_r[0][BIT_LOAD];
  endproperty
  a_enabled_set: assert property (p_enabled_set) else $error("enabled event not flagged");

  property p_irq_low;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && !(|any_flag)) |=> !o_irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt without status");

  property p_zero_match;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ($past(i_clk_en) && $past(i_clk_en, 2) && raw_r[0][BIT_ZERO])
        |-> ($past(count[0], 2) == 16'h0000);
  endproperty
  a_zero_match: assert property (p_zero_match) else $error("zero raw without zero count");

  property p_load_match;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ($past(i_clk_en) && $past(i_clk_en, 2) && raw_r[0][BIT_LOAD])
        |-> ($past(count[0], 2) == $past(act[0][LOAD_MSB:LOAD_LSB], 2));
  endproperty
  a_load_match: assert property (p_load_match) else $error("load raw without load match");

  property p_a_match;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ($past(i_clk_en) && $past(i_clk_en, 2) && raw_r[0][BIT_A_UP])
        |-> ($past(count[0], 2) == $past(cmpa_r[0], 2));
  endproperty
  a_a_match: assert property (p_a_match) else $error("compare A raw without match");

  property p_up_only;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ($past(i_clk_en) && $past(i_clk_en, 2)
        && $past(ctrl_r[0][CTRL_MODE_MSB:CTRL_MODE_LSB], 2) == MODE_UP)
        |-> ((raw_r[0] & 8'hA8) == 8'h00);
  endproperty
  a_up_only: assert property (p_up_only) else $error("down event in up mode");

  property p_down_only;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ($past(i_clk_en) && $past(i_clk_en, 2)
        && $past(ctrl_r[0][CTRL_MODE_MSB:CTRL_MODE_LSB], 2) == MODE_DOWN)
        |-> ((raw_r[0] & 8'h54) == 8'h00);
  endproperty
  a_down_only: assert property (p_down_only) else $error("up event in down mode");

  c_irq: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(o_irq));
  c_clear: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
    wr_done && kind == K_ISC ##1 !o_irq);
  c_updown: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
    ctrl_r[0][CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_UPDOWN && evt[0][BIT_A_DOWN]);
  c_masked: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
    evt[0][BIT_ZERO] && !inten_r[0][BIT_ZERO]);
endmodule
`default_nettype wire

// ===== verilog/pwm_load_shadow.sv
/*
 * Holds the written load and scale and moves them into the active copy
 * at counter zero, optionally only together with the sync input.
 * Assumes zero is a one-cycle pulse from the counter.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_load_shadow
  import pwm_irq_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_clk_en,
  input  wire logic [19:0] i_pend,
  input  wire logic        i_sync_mode,
  input  wire logic        i_sync,
  input  wire logic        i_zero,
  output logic      [19:0] o_act
);
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_act <= LOAD_RESET;
    end else if (i_clk_en && i_zero && (!i_sync_mode || i_sync)) begin
      o_act <= i_pend;
    end
  end

  property p_immediate;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_clk_en && i_zero && !i_sync_mode) |=> (o_act == $past(i_pend));
  endproperty
  a_immediate: assert property (p_immediate) else $error("load not taken at zero");

  property p_synced;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (!(i_clk_en && i_zero && (!i_sync_mode || i_sync))) |=> $stable(o_act);
  endproperty
  a_synced: assert property (p_synced) else $error("load changed without sync zero");
endmodule
`default_nettype wire
